/* File: rtl/smab_pkg.sv */
// smab_pkg: constants, state carriers and lookup functions for the
// drive-health sector builder.
// assumes one 100 MHz clock domain and an Avalon-MM register master.
//
// Contract
// - attribute entry is 12 bytes: id, two flag bytes, value, 8 vendor
// - normalized value byte stays within 01h through FDh
// - zero identifier marks an unused entry, non-zero an active one
// - only the supported identifier set may fill active entries
// - flag bit 0 set means pre-failure, clear means advisory
// - flag bit 1 set means updated on-line, clear off-line only
// - off-line status bit 7 reports automatic collection enabled
// - off-line status low bits hold code 0, 2, 4, 5 or 6
// - self-test bits 0-3 give remaining tens of percent, 0 to 9
// - self-test bits 4-7 give outcome 0 to 7 or 15 running
// - off-line capability bit 2 set aborts, clear suspends on command
// - capability bits 0,1,3,4,6 flag supported off-line features
// - capability word reads 0003h
// - error logging byte has bit 0 set, bits 7-1 zero
// - last byte makes the 512-byte sum wrap to zero
// - threshold sector: revision, 30 entries, zero areas, checksum last
// - threshold entries sit at the same slots as attribute entries
// - threshold entry: id, threshold, then ten zero bytes
// - thresholds are fixed constants no host access can change
// - multi-byte fields go out least significant byte first
// - raw measurements are converted into normalized values
// - attribute sector layout: revision, entries, status bytes, checksum

package smab_pkg;

  localparam logic [5:0]  REG_CTRL      = 6'h00;
  localparam logic [5:0]  REG_OFFLINE   = 6'h04;
  localparam logic [5:0]  REG_SELFTEST  = 6'h08;
  localparam logic [5:0]  REG_ENTRY_SEL = 6'h0C;
  localparam logic [5:0]  REG_ENTRY     = 6'h10;
  localparam logic [5:0]  REG_STATUS    = 6'h14;

  localparam int          CTRL_SEL_THR  = 0;
  localparam int          CTRL_START    = 1;
  localparam int          CTRL_AUTO_EN  = 2;
  localparam int          CTRL_ABORT    = 3;

  localparam int          NUM_ENTRIES   = 30;
  localparam logic [3:0]  ENTRY_LAST_K  = 4'hB;
  localparam logic [8:0]  POS_ENT_FIRST = 9'h002;
  localparam logic [8:0]  POS_ENT_LAST  = 9'h169;
  localparam logic [8:0]  POS_OFF_STAT  = 9'h16A;
  localparam logic [8:0]  POS_ST_STAT   = 9'h16B;
  localparam logic [8:0]  POS_TIME_LO   = 9'h16C;
  localparam logic [8:0]  POS_TIME_HI   = 9'h16D;
  localparam logic [8:0]  POS_OFF_CAP   = 9'h16F;
  localparam logic [8:0]  POS_CAP_LO    = 9'h170;
  localparam logic [8:0]  POS_CAP_HI    = 9'h171;
  localparam logic [8:0]  POS_ERR_CAP   = 9'h172;
  localparam logic [8:0]  POS_SHORT_MIN = 9'h174;
  localparam logic [8:0]  POS_EXT_MIN   = 9'h175;
  localparam logic [8:0]  POS_CSUM      = 9'h1FF;

  localparam logic [15:0] REVISION      = 16'h0010;
  localparam logic [7:0]  OFF_CAP_BASE  = 8'h5B;
  localparam logic [15:0] SMART_CAP     = 16'h0003;
  localparam logic [7:0]  ERR_LOG_CAP   = 8'h01;
  localparam logic [7:0]  NORM_MIN      = 8'h01;
  localparam logic [7:0]  NORM_MAX      = 8'hFD;
  localparam logic [6:0]  OFF_NEVER     = 7'h00;
  localparam logic [3:0]  ST_RUNNING    = 4'hF;
  localparam logic [3:0]  ST_REMAIN_MAX = 4'h9;

  typedef struct packed {
    logic [7:0]  id;
    logic [1:0]  flags;
    logic [7:0]  norm;
    logic [15:0] raw;
  } smab_entry_t;

  typedef struct packed {
    logic                             waitreq;
    logic [31:0]                      rdata;
    logic                             sel_thr;
    logic                             auto_en;
    logic                             abort_cmd;
    logic [6:0]                       off_code;
    logic [3:0]                       st_remain;
    logic [3:0]                       st_outcome;
    logic [4:0]                       ent_sel;
    logic                             active;
    logic                             last;
    logic [8:0]                       pos;
    logic [4:0]                       ent;
    logic [3:0]                       kbyte;
    logic [7:0]                       sum;
    logic [7:0]                       dbyte;
    smab_entry_t [NUM_ENTRIES-1:0]    tab;
  } smab_state_t;

  function automatic logic is_supported(input logic [7:0] id);
    unique case (id)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0C, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7:
        is_supported = 1'b1;
      default: is_supported = 1'b0;
    endcase
  endfunction

  // fixed at build time; nothing writable feeds this table
  function automatic logic [7:0] threshold_of(input logic [7:0] id);
    unique case (id)
      8'h01, 8'h07:        threshold_of = 8'h3E;
      8'h02, 8'h08:        threshold_of = 8'h28;
      8'h03:               threshold_of = 8'h21;
      8'h05, 8'hC4:        threshold_of = 8'h05;
      8'h0A:               threshold_of = 8'h3C;
      default:             threshold_of = 8'h00;
    endcase
  endfunction

  function automatic logic off_code_ok(input logic [6:0] c);
    off_code_ok = (c == 7'h00) || (c == 7'h02) || (c == 7'h04) ||
                  (c == 7'h05) || (c == 7'h06);
  endfunction

endpackage

/* File: rtl/smab_norm.sv */
// smab_norm: maps a raw measurement onto the normalized value scale.
// assumes a larger raw count means a worse condition.
`timescale 1ns/1ps
`default_nettype none

module smab_norm (
  input  wire logic [15:0] raw,
  output logic      [7:0]  norm
);

  // values saturate so the byte never leaves the legal window
  always_comb begin
    if (raw >= 16'(smab_pkg::NORM_MAX - smab_pkg::NORM_MIN)) begin
      norm = smab_pkg::NORM_MIN;
    end else begin
      norm = smab_pkg::NORM_MAX - raw[7:0];
    end
  end

endmodule

`default_nettype wire

/* File: rtl/smab_builder.sv */
// smab_builder: holds the attribute table and status bytes and streams
// either the attribute sector or the threshold sector byte by byte.
// assumes an Avalon-MM master on the same clock and a same-clock
// transfer strobe from the host-interface logic.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module smab_builder #(
  parameter int OFFLINE_SECS = 600,
  parameter int SHORT_MINS   = 2,
  parameter int EXT_MINS     = 90
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        xfer_strobe,
  output logic      [7:0]  xfer_byte,
  output logic             xfer_valid,
  output logic             xfer_last
);

  // refused at elaboration: the sector fields are 16 and 8 bits wide
  if (OFFLINE_SECS < 0 || OFFLINE_SECS > 65535) begin
    $error("off-line time does not fit 16 bits");
  end
  if (SHORT_MINS < 0 || SHORT_MINS > 255) begin
    $error("short self-test time does not fit 8 bits");
  end
  if (EXT_MINS < 0 || EXT_MINS > 255) begin
    $error("extended self-test time does not fit 8 bits");
  end

  localparam logic [15:0] OFF_TIME  = 16'(OFFLINE_SECS);
  localparam logic [7:0]  SHORT_T   = 8'(SHORT_MINS);
  localparam logic [7:0]  EXT_T     = 8'(EXT_MINS);

  smab_pkg::smab_state_t st_reg;
  smab_pkg::smab_state_t st_next;
  logic [7:0]            wr_norm;

  smab_norm u_norm (
    .raw  (avs_writedata[31:16]),
    .norm (wr_norm)
  );

  // byte of one 12-byte slot for either sector
  function automatic logic [7:0] entry_byte(
    input smab_pkg::smab_entry_t e,
    input logic                  thr,
    input logic [3:0]            k
  );
    logic [7:0] b;
    b = 8'h00;
    if (e.id == 8'h00) begin
      b = 8'h00;
    end else if (thr) begin
      unique case (k)
        4'h0:    b = e.id;
        4'h1:    b = smab_pkg::threshold_of(e.id);
        default: b = 8'h00;
      endcase
    end else begin
      unique case (k)
        4'h0:    b = e.id;
        4'h1:    b = {6'h00, e.flags};
        4'h2:    b = 8'h00;
        4'h3:    b = e.norm;
        4'h4:    b = e.raw[7:0];
        4'h5:    b = e.raw[15:8];
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  // byte at a sector position outside the entry area
  function automatic logic [7:0] fixed_byte(
    input smab_pkg::smab_state_t s,
    input logic [8:0]            p
  );
    logic [7:0] b;
    b = 8'h00;
    if (p == 9'h000) begin
      b = smab_pkg::REVISION[7:0];
    end else if (p == 9'h001) begin
      b = smab_pkg::REVISION[15:8];
    end else if (s.sel_thr) begin
      b = 8'h00;
    end else begin
      unique case (p)
        smab_pkg::POS_OFF_STAT:  b = {s.auto_en, s.off_code};
        smab_pkg::POS_ST_STAT:   b = {s.st_outcome, s.st_remain};
        smab_pkg::POS_TIME_LO:   b = OFF_TIME[7:0];
        smab_pkg::POS_TIME_HI:   b = OFF_TIME[15:8];
        smab_pkg::POS_OFF_CAP:   b = smab_pkg::OFF_CAP_BASE |
                                     {5'h00, s.abort_cmd, 2'h0};
        smab_pkg::POS_CAP_LO:    b = smab_pkg::SMART_CAP[7:0];
        smab_pkg::POS_CAP_HI:    b = smab_pkg::SMART_CAP[15:8];
        smab_pkg::POS_ERR_CAP:   b = smab_pkg::ERR_LOG_CAP;
        smab_pkg::POS_SHORT_MIN: b = SHORT_T;
        smab_pkg::POS_EXT_MIN:   b = EXT_T;
        default:                 b = 8'h00;
      endcase
    end
    return b;
  endfunction

  function automatic logic in_entries(input logic [8:0] p);
    in_entries = (p >= smab_pkg::POS_ENT_FIRST) &&
                 (p <= smab_pkg::POS_ENT_LAST);
  endfunction

  always_comb begin
    logic [8:0]  npos;
    logic [4:0]  nent;
    logic [3:0]  nk;
    logic [7:0]  nsum;
    logic [7:0]  nbyte;
    logic        req;
    logic        take;
    logic        done;
    logic [31:0] rd;
    npos    = 9'h000;
    nent    = 5'h00;
    nk      = 4'h0;
    nsum    = 8'h00;
    nbyte   = 8'h00;
    rd      = 32'h0000_0000;
    st_next = st_reg;
    req     = avs_read || avs_write;
    // one wait state: the answer comes on the second edge of a request
    take    = req && st_reg.waitreq;
    // writes land on the edge that ends the wait, as the master sees it
    done    = req && !st_reg.waitreq;

    st_next.waitreq = !take;

    // stream advance on each strobe while a sector is open
    if (st_reg.active && xfer_strobe) begin
      if (st_reg.last) begin
        st_next.active = 1'b0;
        st_next.last   = 1'b0;
      end else begin
        npos = st_reg.pos + 9'h001;
        nent = st_reg.ent;
        nk   = st_reg.kbyte;
        if (in_entries(st_reg.pos)) begin
          if (st_reg.kbyte == smab_pkg::ENTRY_LAST_K) begin
            nk   = 4'h0;
            nent = st_reg.ent + 5'h01;
          end else begin
            nk = st_reg.kbyte + 4'h1;
          end
        end
        nsum = st_reg.sum + st_reg.dbyte;
        if (npos == smab_pkg::POS_CSUM) begin
          nbyte = 8'h00 - nsum;
        end else if (in_entries(npos)) begin
          nbyte = entry_byte(st_reg.tab[nent], st_reg.sel_thr, nk);
        end else begin
          nbyte = fixed_byte(st_reg, npos);
        end
        st_next.pos   = npos;
        st_next.ent   = nent;
        st_next.kbyte = nk;
        st_next.sum   = nsum;
        st_next.dbyte = nbyte;
        st_next.last  = (npos == smab_pkg::POS_CSUM);
      end
    end

    if (done && avs_write) begin
      unique case (avs_address)
        smab_pkg::REG_CTRL: begin
          st_next.auto_en   = avs_writedata[smab_pkg::CTRL_AUTO_EN];
          st_next.abort_cmd = avs_writedata[smab_pkg::CTRL_ABORT];
          if (avs_writedata[smab_pkg::CTRL_START]) begin
            // a start restarts any open sector from byte zero
            st_next.sel_thr = avs_writedata[smab_pkg::CTRL_SEL_THR];
            st_next.active  = 1'b1;
            st_next.last    = 1'b0;
            st_next.pos     = 9'h000;
            st_next.ent     = 5'h00;
            st_next.kbyte   = 4'h0;
            st_next.sum     = 8'h00;
            st_next.dbyte   = smab_pkg::REVISION[7:0];
          end
        end
        smab_pkg::REG_OFFLINE: begin
          if (smab_pkg::off_code_ok(avs_writedata[6:0])) begin
            st_next.off_code = avs_writedata[6:0];
          end
        end
        smab_pkg::REG_SELFTEST: begin
          if (avs_writedata[3:0] <= smab_pkg::ST_REMAIN_MAX) begin
            st_next.st_remain = avs_writedata[3:0];
          end
          if (avs_writedata[7:4] <= 4'h7 ||
              avs_writedata[7:4] == smab_pkg::ST_RUNNING) begin
            st_next.st_outcome = avs_writedata[7:4];
          end
        end
        smab_pkg::REG_ENTRY_SEL: begin
          if (avs_writedata[4:0] < 5'(smab_pkg::NUM_ENTRIES)) begin
            st_next.ent_sel = avs_writedata[4:0];
          end
        end
        smab_pkg::REG_ENTRY: begin
          // unsupported identifiers leave the slot unused
          if (smab_pkg::is_supported(avs_writedata[7:0])) begin
            st_next.tab[st_reg.ent_sel].id = avs_writedata[7:0];
          end else begin
            st_next.tab[st_reg.ent_sel].id = 8'h00;
          end
          st_next.tab[st_reg.ent_sel].flags = avs_writedata[9:8];
          st_next.tab[st_reg.ent_sel].raw   = avs_writedata[31:16];
          st_next.tab[st_reg.ent_sel].norm  = wr_norm;
        end
        default: begin
        end
      endcase
    end

    if (take && avs_read) begin
      unique case (avs_address)
        smab_pkg::REG_CTRL:
          rd = {28'h0000000, st_reg.abort_cmd, st_reg.auto_en, 1'b0,
                st_reg.sel_thr};
        smab_pkg::REG_OFFLINE:
          rd = {24'h000000, st_reg.auto_en, st_reg.off_code};
        smab_pkg::REG_SELFTEST:
          rd = {24'h000000, st_reg.st_outcome, st_reg.st_remain};
        smab_pkg::REG_ENTRY_SEL:
          rd = {27'h0000000, st_reg.ent_sel};
        smab_pkg::REG_ENTRY:
          rd = {8'h00, st_reg.tab[st_reg.ent_sel].norm, 6'h00,
                st_reg.tab[st_reg.ent_sel].flags,
                st_reg.tab[st_reg.ent_sel].id};
        smab_pkg::REG_STATUS:
          rd = {7'h00, st_reg.pos, st_reg.sum, 6'h00, st_reg.last,
                st_reg.active};
        default:
          rd = 32'h0000_0000;
      endcase
      st_next.rdata = rd;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.waitreq    <= 1'b1;
      st_reg.off_code   <= smab_pkg::OFF_NEVER;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign xfer_byte       = st_reg.dbyte;
  assign xfer_valid      = st_reg.active;
  assign xfer_last       = st_reg.last;

endmodule

`default_nettype wire

/* File: sim/smab_monitor.sv */
// smab_monitor: bus and sector-stream checks on smab_builder ports.
// assumes one clock and a sector started by a CTRL start write.
`timescale 1ns/1ps
`default_nettype none
module smab_monitor (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        xfer_strobe,
  input wire logic [7:0]  xfer_byte,
  input wire logic        xfer_valid,
  input wire logic        xfer_last
);
  logic [9:0] pos_reg;
  logic [7:0] sum_reg;
  logic [7:0] id_reg;
  logic       thr_reg;
  logic       go;
  logic       ent;
  logic [9:0] k;
  assign go  = avs_write && !avs_waitrequest && avs_address == 6'h00 &&
               avs_writedata[1];
  assign ent = pos_reg >= 10'h002 && pos_reg <= 10'h169;
  assign k   = (pos_reg - 10'h002) % 10'h00C;
  // own position count, so layout checks need no design internals
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 10'h000;
      sum_reg <= 8'h00;
      id_reg  <= 8'h00;
      thr_reg <= 1'b0;
    end else if (go) begin
      pos_reg <= 10'h000;
      sum_reg <= 8'h00;
      thr_reg <= avs_writedata[0];
    end else if (xfer_strobe && xfer_valid) begin
      pos_reg <= pos_reg + 10'h001;
      sum_reg <= sum_reg + xfer_byte;
      if (ent && k == 10'h000) begin
        id_reg <= xfer_byte;
      end
    end
  end
  default clocking mclk @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait state count wrong");
  a_rev_first: assert property (
    go |=> xfer_valid && xfer_byte == 8'h10)
    else $error("sector does not open with revision");
  a_last_pos: assert property (
    xfer_valid |-> xfer_last == (pos_reg == 10'h1FF))
    else $error("last flag at wrong byte");
  a_sum_zero: assert property (xfer_valid && xfer_last |->
    sum_reg + xfer_byte == 8'h00) else $error("sector sum not zero");
  a_end_drop: assert property (
    xfer_valid && xfer_last && xfer_strobe && !go |=> !xfer_valid)
    else $error("stream open after last byte");
  a_byte_hold: assert property (xfer_valid && !xfer_strobe && !go
    |=> xfer_valid && $stable(xfer_byte)) else $error("byte moved unasked");
  a_norm_range: assert property (
    xfer_valid && !thr_reg && ent && k == 10'h003 && id_reg != 8'h00
    |-> xfer_byte inside {[8'h01:8'hFD]})
    else $error("normalized value out of range");
  a_thr_zero: assert property (
    xfer_valid && thr_reg && (ent && k > 10'h001 ||
    pos_reg inside {[10'h16A:10'h1FE]}) |-> xfer_byte == 8'h00)
    else $error("threshold sector byte not zero");
  a_cap_bytes: assert property (
    xfer_valid && !thr_reg && pos_reg inside {10'h170, 10'h172}
    |-> xfer_byte == (pos_reg[1] ? 8'h01 : 8'h03))
    else $error("capability byte wrong");
  c_attr: cover property (go && !avs_writedata[0]);
  c_thr: cover property (go && avs_writedata[0]);
  c_end: cover property (xfer_last && xfer_strobe);
endmodule
bind smab_builder smab_monitor smab_monitor_i (.clock, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .xfer_strobe, .xfer_byte, .xfer_valid, .xfer_last);
`default_nettype wire

/* File: sim/smab_host.sv */
// smab_host: host that reads each sector whole through the strobe.
// assumes the block's clock; slow mode stalls at random.
`timescale 1ns/1ps
`default_nettype none
module smab_host (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic xfer_valid,
  input  wire logic xfer_last,
  output logic      xfer_strobe
);
  // never quits early: a partial sector is not a legal read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xfer_strobe <= 1'b0;
    end else begin
      xfer_strobe <= xfer_valid && !(xfer_last && xfer_strobe) &&
                     (!slow || $urandom_range(2) == 0);
    end
  end
endmodule
`default_nettype wire

/* File: sim/smab_builder_tb.sv */
// smab_builder_tb: register and sector checks for smab_builder.
// assumes smab_host reads the sectors and smab_monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module smab_builder_tb;
  localparam int SECS = 300;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        slow = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        xfer_strobe;
  logic [7:0]  xfer_byte;
  logic        xfer_valid;
  logic        xfer_last;
  int          fails = 0;
  int          check_count = 0;
  logic [31:0] rq[$];
  logic [7:0]  bq[$];
  logic [7:0]  t_id[30];
  logic [1:0]  t_fl[30];
  logic [15:0] t_raw[30];
  logic [7:0]  off_b = 8'h00;
  logic [7:0]  st_b = 8'h00;
  logic        abt = 1'b0;
  logic [7:0]  sup[17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0C, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
  always #5 clock = ~clock;
  smab_builder #(.OFFLINE_SECS(SECS), .SHORT_MINS(2), .EXT_MINS(90))
    smab_builder_i (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .xfer_strobe,
    .xfer_byte, .xfer_valid, .xfer_last);
  smab_host smab_host_i (.clock, .rst_n, .slow, .xfer_valid, .xfer_last,
    .xfer_strobe);
  task automatic stop_test();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic err(input string m);
    fails++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmp_word(input logic [31:0] e, input logic [31:0] a);
    check_count++;
    if (a !== e) err($sformatf("read %h exp %h", a, e));
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] a);
    check_count++;
    if (a !== e) err($sformatf("byte %h exp %h", a, e));
  endtask
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest && n < 50);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      err("bus timeout");
      stop_test();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask
  function automatic logic [7:0] norm_of(input logic [15:0] raw);
    return raw < 16'h00FC ? 8'hFD - raw[7:0] : 8'h01;
  endfunction
  function automatic logic [7:0] thr_of(input logic [7:0] id);
    case (id)
      8'h01, 8'h07: return 8'h3E;
      8'h02, 8'h08: return 8'h28;
      8'h03: return 8'h21;
      8'h05, 8'hC4: return 8'h05;
      8'h0A: return 8'h3C;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] exp_byte(input logic thr, input int p);
    int s;
    int k;
    s = (p - 2) / 12;
    k = (p - 2) % 12;
    if (p < 2) return p == 0 ? 8'h10 : 8'h00;
    if (p < 362) begin
      if (t_id[s] == 8'h00) return 8'h00;
      if (k == 0) return t_id[s];
      if (k == 1) return thr ? thr_of(t_id[s]) : {6'h00, t_fl[s]};
      if (thr || k == 2 || k > 5) return 8'h00;
      return k == 3 ? norm_of(t_raw[s]) : t_raw[s][8*(k-4) +: 8];
    end
    if (thr) return 8'h00;
    case (p)
      9'h16A: return off_b;
      9'h16B: return st_b;
      9'h16C: return 8'(SECS);
      9'h16D: return 8'(SECS >> 8);
      9'h16F: return 8'h5B | {5'h00, abt, 2'h0};
      9'h170: return 8'h03;
      9'h172: return 8'h01;
      9'h174: return 8'h02;
      9'h175: return 8'h5A;
      default: return 8'h00;
    endcase
  endfunction
  task automatic sector(input logic thr, input logic [31:0] c);
    logic [7:0] sum;
    int n;
    sum = 8'h00;
    n = 0;
    off_b[7] = c[2];
    abt = c[3];
    for (int p = 0; p < 511; p++) begin
      bq.push_back(exp_byte(thr, p));
      sum += exp_byte(thr, p);
    end
    bq.push_back(8'h00 - sum);
    bus(1'b1, 6'h00, c);
    @(posedge clock);
    while (xfer_valid && n < 5000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 5000) begin
      err("sector timeout");
      stop_test();
    end
    if (bq.size() != 0) err("sector incomplete");
  endtask
  // scoreboard: oldest note meets each result as it appears
  always @(posedge clock) begin
    if (rst_n && avs_read && !avs_waitrequest)
      cmp_word(rq.size() > 0 ? rq.pop_front() : 'x, avs_readdata);
    if (rst_n && xfer_strobe && xfer_valid)
      cmp_byte(bq.size() > 0 ? bq.pop_front() : 'x, xfer_byte);
  end
  initial begin
    int r;
    logic [7:0] id;
    logic [7:0] b;
    logic [6:0] oc[7];
    oc = '{7'h03, 7'h00, 7'h02, 7'h7F, 7'h04, 7'h06, 7'h05};
    void'($urandom(32'h409E));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(6'h14, 32'h00000000);
    rd(6'h3C, 32'h00000000);
    for (int i = 0; i < 30; i++) begin
      r = $urandom % 20;
      id = r < 17 ? sup[r] : (r == 17 ? 8'h06 : 8'h00);
      t_fl[i] = 2'($urandom);
      t_raw[i] = 16'($urandom % 300);
      t_id[i] = id inside {sup} ? id : 8'h00;
      bus(1'b1, 6'h0C, 32'(i));
      bus(1'b1, 6'h10, {t_raw[i], 6'h00, t_fl[i], id});
      if (t_id[i] != 8'h00)
        rd(6'h10, {8'h00, norm_of(t_raw[i]), 6'h00, t_fl[i], id});
    end
    // slot 31 is out of range and must leave the selection at 29
    bus(1'b1, 6'h0C, 32'h0000001F);
    rd(6'h0C, 32'h0000001D);
    foreach (oc[j]) begin
      bus(1'b1, 6'h04, {25'h0, oc[j]});
      if (oc[j] inside {7'h00, 7'h02, 7'h04, 7'h05, 7'h06}) off_b[6:0] = oc[j];
      rd(6'h04, {24'h0, off_b});
    end
    for (int o = 0; o < 16; o++) begin
      b = {4'(o), 4'($urandom % 11)};
      bus(1'b1, 6'h08, {24'h0, b});
      if (b[3:0] <= 4'h9) st_b[3:0] = b[3:0];
      if (b[7:4] <= 4'h7 || b[7:4] == 4'hF) st_b[7:4] = b[7:4];
      rd(6'h08, {24'h0, st_b});
    end
    sector(1'b0, 32'h0000000E);
    rd(6'h00, 32'h0000000C);
    rd(6'h04, {24'h0, off_b});
    slow <= 1'b1;
    sector(1'b1, 32'h00000003);
    sector(1'b0, 32'h00000002);
    stop_test();
  end
endmodule
`default_nettype wire
